// ---- src/ips_top.sv ----
// Input-driven position sequencer with linear and rotary modes.
//
// Functional notes
// - Linear trigger closing starts move to point.
// - Six select bits form the point index.
// - Closed-active enable drives while input closed.
// - Open-active enable drives while input open.
// - Limit inputs block motion that direction.
// - Homing sensor polarity low or high.
// - Rotary trigger advances exactly one point.
// - Revolution split into configured equal points.
// - Rotary direction setting applies each step.
// - Homing search has its own direction.
// - Per-point offset added to rotary target.
// - Rotary and homing use own profiles.
// - Stop request aborts motion at once.
// - Select input reads 0 closed, 1 open.
// - Targets scaled at 10000 counts per rev.
// - Move triggers accepted only after homing completes.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ips_consts.svh"
module ips_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ips_pkg::ips_word_t reg_rdata,
  input wire logic home_sensor_in,
  input wire logic home_trigger_in,
  input wire logic servo_enable_in,
  input wire logic move_trigger_in,
  input wire logic cw_limit_in,
  input wire logic ccw_limit_in,
  input wire logic stop_req_n,
  input wire logic [5:0] point_select_in,
  input wire logic move_done_in,
  output logic drive_enable,
  output logic move_start,
  output ips_pkg::ips_word_t target_pos,
  output logic move_cw,
  output logic [15:0] prof_vel,
  output logic [15:0] prof_acc,
  output logic [15:0] prof_dec,
  output logic home_seek,
  output logic motion_abort,
  output logic homed
);
  import ips_pkg::*;

  // Synchronised pins and their closing edges.
  logic [12:0] lvl;
  logic [12:0] fall;
  ips_sync #(.W(13)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin({point_select_in, stop_req_n, ccw_limit_in, cw_limit_in,
          move_trigger_in, servo_enable_in, home_trigger_in, home_sensor_in}),
    .lvl(lvl),
    .fall(fall)
  );

  // Rotary divider link.
  ips_div_if dv ();
  ips_div u_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .dv(dv)
  );

  // Software settings.
  logic [5:0] ctrl_ff;
  logic [5:0] nxt_ctrl;
  logic [15:0] divs_ff;
  logic [15:0] nxt_divs;
  logic [31:0] hofs_ff;
  logic [31:0] nxt_hofs;
  logic [5:0] psel_ff;
  logic [5:0] nxt_psel;
  logic [15:0] prof_ff [0:8];
  logic [31:0] lpos_mem [0:63];
  logic [15:0] rofs_mem [0:63];
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  // The stop bit is a write pulse, never stored.
  logic sw_stop;

  // Sequencer state.
  ips_state_e st_ff;
  ips_state_e nxt_st;
  logic [5:0] step_ff;
  logic [5:0] nxt_step;
  logic [31:0] tgt_ff;
  logic [31:0] nxt_tgt;
  logic [31:0] pos_ff;
  logic [31:0] nxt_pos;
  logic [3:0] pset_ff;
  logic [3:0] nxt_pset;
  logic cw_ff;
  logic nxt_cw;
  logic start_ff;
  logic nxt_start;
  logic abort_ff;
  logic nxt_abort;
  logic homed_ff;
  logic nxt_homed;
  logic en_ff;
  logic nxt_en;

  // Decoded inputs; closed reads as logic 0.
  logic [5:0] pt_idx;
  logic [31:0] lin_pick;
  logic cw_lim;
  logic ccw_lim;
  logic sen_act;
  logic stop_ev;
  logic lim_hit;
  logic [5:0] div_last;
  logic [5:0] rot_next;
  logic [3:0] pidx;

  assign pt_idx = lvl[12:7];
  assign lin_pick = lpos_mem[pt_idx];
  assign cw_lim = ~lvl[`IPS_I_CWL];
  assign ccw_lim = ~lvl[`IPS_I_CCWL];
  assign sen_act = ctrl_ff[`IPS_B_HOME_HI] ? lvl[`IPS_I_HSEN] : ~lvl[`IPS_I_HSEN];
  assign stop_ev = fall[`IPS_I_STOP] | sw_stop;
  assign lim_hit = cw_ff ? cw_lim : ccw_lim;
  assign div_last = divs_ff[5:0] - 6'h01;
  assign pidx = 4'(reg_addr[5:2] - 4'h3);

  // Next step in the set rotary direction, wrapping after the last point.
  always_comb
  begin
    if (!ctrl_ff[`IPS_B_ROT_CCW])
      rot_next = (step_ff >= div_last) ? 6'h00 : step_ff + 6'h01;
    else
      rot_next = (step_ff == 6'h00) ? div_last : step_ff - 6'h01;
  end

  // Register writes and read data, one cycle late.
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_divs = divs_ff;
    nxt_hofs = hofs_ff;
    nxt_psel = psel_ff;
    sw_stop = 1'b0;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr)
    begin
      case (reg_addr)
        `IPS_A_CTRL:
        begin
          nxt_ctrl = {1'b0, reg_wdata[4:0]};
          sw_stop = reg_wdata[`IPS_B_STOP];
        end
        // At least one point; more than 64 would overflow the offset table.
        `IPS_A_DIVS: nxt_divs = (reg_wdata[15:0] == 16'h0000) ? 16'h0001 :
                                (reg_wdata[15:0] > 16'h0040) ? 16'h0040 : reg_wdata[15:0];
        `IPS_A_HOFS: nxt_hofs = reg_wdata;
        `IPS_A_PSEL: nxt_psel = reg_wdata[5:0];
        default: nxt_psel = psel_ff;
      endcase
    end
    if (reg_rd)
    begin
      if (reg_addr >= `IPS_A_PROF0 && reg_addr <= `IPS_A_PROF8)
        nxt_rdata = {16'h0000, prof_ff[pidx]};
      else
      begin
        case (reg_addr)
          `IPS_A_CTRL: nxt_rdata = {26'h000_0000, ctrl_ff};
          `IPS_A_DIVS: nxt_rdata = {16'h0000, divs_ff};
          `IPS_A_HOFS: nxt_rdata = hofs_ff;
          `IPS_A_PSEL: nxt_rdata = {26'h000_0000, psel_ff};
          `IPS_A_LPOS: nxt_rdata = lpos_mem[psel_ff];
          `IPS_A_ROFS: nxt_rdata = {16'h0000, rofs_mem[psel_ff]};
          `IPS_A_STAT: nxt_rdata = {12'h000, st_ff, homed_ff, en_ff, cw_lim, ccw_lim,
                                    sen_act, step_ff, pt_idx};
          default: nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register file storage; tables are written in place.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ctrl_ff <= 6'h00;
      divs_ff <= `IPS_R_DIVS;
      hofs_ff <= 32'h0000_0000;
      psel_ff <= 6'h00;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      divs_ff <= nxt_divs;
      hofs_ff <= nxt_hofs;
      psel_ff <= nxt_psel;
      rdata_ff <= nxt_rdata;
    end
  end

  // Tables carry no reset; software loads them before use.
  always_ff @(posedge ref_clk)
  begin
    if (reg_wr && reg_addr >= `IPS_A_PROF0 && reg_addr <= `IPS_A_PROF8)
      prof_ff[pidx] <= reg_wdata[15:0];
    if (reg_wr && reg_addr == `IPS_A_LPOS)
      lpos_mem[psel_ff] <= reg_wdata;
    if (reg_wr && reg_addr == `IPS_A_ROFS)
      rofs_mem[psel_ff] <= reg_wdata[15:0];
  end

  // Divider request: point number times counts per revolution over points.
  assign dv.start = (st_ff == IPS_IDLE) && homed_ff && ctrl_ff[`IPS_B_ROTARY] &&
                    fall[`IPS_I_MTRG] && !stop_ev;
  assign dv.dividend = 24'(rot_next * `IPS_COUNTS_REV);
  assign dv.divisor = divs_ff;

  // Sequencer next state.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_step = step_ff;
    nxt_tgt = tgt_ff;
    nxt_pos = pos_ff;
    nxt_pset = pset_ff;
    nxt_cw = cw_ff;
    nxt_start = 1'b0;
    nxt_abort = 1'b0;
    nxt_homed = homed_ff;
    // Drive enable follows the pin in the selected sense.
    nxt_en = ctrl_ff[`IPS_B_SEN_OPEN] ? lvl[`IPS_I_SEN] : ~lvl[`IPS_I_SEN];
    case (st_ff)
      IPS_IDLE:
      begin
        if (stop_ev)
          nxt_st = IPS_IDLE;
        else if (fall[`IPS_I_HTRG])
        begin
          nxt_st = IPS_SEEK;
          nxt_cw = ~ctrl_ff[`IPS_B_HOME_CCW];
          nxt_pset = `IPS_P_HOME;
          nxt_homed = 1'b0;
        end
        else if (fall[`IPS_I_MTRG] && homed_ff)
        begin
          if (ctrl_ff[`IPS_B_ROTARY])
          begin
            nxt_st = IPS_CALC;
            nxt_step = rot_next;
            nxt_cw = ~ctrl_ff[`IPS_B_ROT_CCW];
            nxt_pset = `IPS_P_ROT;
          end
          else
          begin
            nxt_st = IPS_MOVE;
            nxt_tgt = lin_pick;
            nxt_cw = $signed(lin_pick) >= $signed(pos_ff);
            nxt_pset = `IPS_P_LIN;
            nxt_start = 1'b1;
          end
        end
      end
      IPS_CALC:
      begin
        if (stop_ev)
        begin
          nxt_st = IPS_IDLE;
          nxt_abort = 1'b1;
        end
        else if (dv.done)
        begin
          nxt_st = IPS_MOVE;
          nxt_tgt = {8'h00, dv.quot} + {{16{rofs_mem[step_ff][15]}}, rofs_mem[step_ff]};
          nxt_start = 1'b1;
        end
      end
      IPS_MOVE, IPS_HOFS:
      begin
        // A limit ahead or a stop ends the move without waiting for the loop.
        if (stop_ev || lim_hit)
        begin
          nxt_st = IPS_IDLE;
          nxt_abort = 1'b1;
        end
        else if (move_done_in)
        begin
          nxt_st = IPS_IDLE;
          nxt_pos = tgt_ff;
          if (st_ff == IPS_HOFS)
          begin
            nxt_homed = 1'b1;
            nxt_step = 6'h00;
          end
        end
      end
      IPS_SEEK:
      begin
        if (stop_ev || lim_hit)
        begin
          nxt_st = IPS_IDLE;
          nxt_abort = 1'b1;
        end
        else if (sen_act)
        begin
          // The sensor edge defines zero; the offset move follows.
          nxt_st = IPS_HOFS;
          nxt_pos = 32'h0000_0000;
          nxt_tgt = hofs_ff;
          nxt_cw = ~hofs_ff[31];
          nxt_start = 1'b1;
        end
      end
      default: nxt_st = IPS_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_ff <= IPS_IDLE;
      step_ff <= 6'h00;
      tgt_ff <= 32'h0000_0000;
      pos_ff <= 32'h0000_0000;
      pset_ff <= `IPS_P_LIN;
      cw_ff <= 1'b1;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      homed_ff <= 1'b0;
      en_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      step_ff <= nxt_step;
      tgt_ff <= nxt_tgt;
      pos_ff <= nxt_pos;
      pset_ff <= nxt_pset;
      cw_ff <= nxt_cw;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
      homed_ff <= nxt_homed;
      en_ff <= nxt_en;
    end
  end

  // Outputs; profiles come straight from the chosen set.
  assign reg_rdata = rdata_ff;
  assign drive_enable = en_ff;
  assign move_start = start_ff;
  assign target_pos = tgt_ff;
  assign move_cw = cw_ff;
  assign prof_vel = prof_ff[pset_ff];
  assign prof_acc = prof_ff[4'(pset_ff + 4'h1)];
  assign prof_dec = prof_ff[4'(pset_ff + 4'h2)];
  assign home_seek = (st_ff == IPS_SEEK);
  assign motion_abort = abort_ff;
  assign homed = homed_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_lin_start: assert property ((st_ff == IPS_IDLE) && homed_ff && !ctrl_ff[0] &&
    fall[3] && !fall[1] && !stop_ev |=> move_start && st_ff == IPS_MOVE)
    else $error("linear trigger did not start a move");
  chk_lin_target: assert property ((st_ff == IPS_IDLE) && homed_ff && !ctrl_ff[0] &&
    fall[3] && !fall[1] && !stop_ev |=> target_pos == $past(lin_pick))
    else $error("linear target is not the selected point");
  chk_en_closed: assert property (!ctrl_ff[1] && !lvl[2] ##1 !ctrl_ff[1] |-> drive_enable)
    else $error("drive not enabled with input closed");
  chk_en_open: assert property (ctrl_ff[1] && !lvl[2] ##1 ctrl_ff[1] |-> !drive_enable)
    else $error("drive enabled with input closed in open mode");
  chk_limit_abort: assert property ((st_ff == IPS_MOVE) && move_cw && cw_lim |=>
    motion_abort ##1 !move_start)
    else $error("move continued into active limit");
  chk_no_unhomed: assert property (!homed_ff && (st_ff == IPS_IDLE) && !fall[1] |=>
    st_ff == IPS_IDLE)
    else $error("trigger accepted before homing");
  chk_stop_abort: assert property ((st_ff != IPS_IDLE) && stop_ev |=>
    motion_abort && st_ff == IPS_IDLE)
    else $error("stop did not abort motion");
  chk_rot_move: assert property ((st_ff == IPS_CALC) ##1 (st_ff == IPS_CALC)[*1] |->
    ##[0:30] (st_ff != IPS_CALC))
    else $error("rotary target took too long");
  chk_rot_dir: assert property ($rose(st_ff == IPS_CALC) |-> move_cw == !ctrl_ff[3])
    else $error("rotary step in wrong direction");
  chk_home_seek: assert property ((st_ff == IPS_SEEK) && sen_act && !stop_ev &&
    !lim_hit |=> move_start && target_pos == $past(hofs_ff))
    else $error("sensor did not end the homing search");
  cov_lin: cover property (move_start && !ctrl_ff[0]);
  cov_rot: cover property ((st_ff == IPS_CALC) ##[1:30] move_start);
  cov_home: cover property ($rose(homed_ff));
  cov_abort: cover property (motion_abort);
endmodule // ips_top
`default_nettype wire

// ---- pkg/ips_consts.svh ----
// Offsets, field positions, reset values and counts of the position sequencer.
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH
// Register byte offsets.
`define IPS_A_CTRL 8'h00
`define IPS_A_DIVS 8'h04
`define IPS_A_HOFS 8'h08
`define IPS_A_PROF0 8'h0C
`define IPS_A_PROF8 8'h2C
`define IPS_A_PSEL 8'h30
`define IPS_A_LPOS 8'h34
`define IPS_A_ROFS 8'h38
`define IPS_A_STAT 8'h3C
// Control register fields.
`define IPS_B_ROTARY 0
`define IPS_B_SEN_OPEN 1
`define IPS_B_HOME_HI 2
`define IPS_B_ROT_CCW 3
`define IPS_B_HOME_CCW 4
`define IPS_B_STOP 5
// Profile set base indices: linear, rotary, homing.
`define IPS_P_LIN 4'h0
`define IPS_P_ROT 4'h3
`define IPS_P_HOME 4'h6
// Synchronised pin vector positions.
`define IPS_I_HSEN 0
`define IPS_I_HTRG 1
`define IPS_I_SEN 2
`define IPS_I_MTRG 3
`define IPS_I_CWL 4
`define IPS_I_CCWL 5
`define IPS_I_STOP 6
`define IPS_I_PT 7
// Reset values and scaling.
`define IPS_R_DIVS 16'h0018
`define IPS_COUNTS_REV 18'h0_2710
`define IPS_DIV_BITS 24
`endif

// ---- pkg/ips_pkg.sv ----
// Types shared by the position sequencer modules.
package ips_pkg;
  // Sequencer states, Gray coded along idle-calc-move and idle-seek-offset.
  typedef enum logic [2:0] {
    IPS_IDLE = 3'h0,
    IPS_CALC = 3'h1,
    IPS_MOVE = 3'h3,
    IPS_SEEK = 3'h2,
    IPS_HOFS = 3'h6
  } ips_state_e;
  typedef logic [31:0] ips_word_t;
endpackage

// ---- pkg/ips_div_if.sv ----
// Request and answer between the sequencer and its rotary divider.
`timescale 1ns/1ps
`default_nettype none
interface ips_div_if;
  logic start;
  logic [23:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic [23:0] quot;
  modport master (output start, output dividend, output divisor, input done, input quot);
  modport slave (input start, input dividend, input divisor, output done, output quot);
endinterface
`default_nettype wire

// ---- src/ips_sync.sv ----
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/1ps
`default_nettype none
module ips_sync #(
  parameter int W = 13
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] fall
);
  // Pins idle open, so every stage resets high.
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;
  logic [W-1:0] nxt_s3;

  // Next values: the first stage is read only by the second.
  always_comb
  begin
    nxt_s1 = pin;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end

  // Register the chain.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
    end
  end

  // Open to closed is a falling level; the pulse lasts one cycle.
  assign lvl = s2_ff;
  assign fall = s3_ff & ~s2_ff;
endmodule // ips_sync
`default_nettype wire

// ---- src/ips_div.sv ----
// Sequential restoring divider for rotary point targets.
`timescale 1ns/1ps
`default_nettype none
`include "ips_consts.svh"
module ips_div (
  input wire logic ref_clk,
  input wire logic resetn,
  ips_div_if.slave dv
);
  logic [23:0] q_ff;
  logic [23:0] nxt_q;
  logic [16:0] r_ff;
  logic [16:0] nxt_r;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  logic [16:0] trial;

  // One quotient bit per cycle; a zero divisor yields all ones.
  always_comb
  begin
    trial = {r_ff[15:0], q_ff[23]};
    nxt_q = q_ff;
    nxt_r = r_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (dv.start)
    begin
      nxt_q = dv.dividend;
      nxt_r = 17'h0_0000;
      nxt_cnt = 5'h00;
      nxt_busy = 1'b1;
    end
    else if (busy_ff)
    begin
      if (trial >= {1'b0, dv.divisor})
      begin
        nxt_r = trial - {1'b0, dv.divisor};
        nxt_q = {q_ff[22:0], 1'b1};
      end
      else
      begin
        nxt_r = trial;
        nxt_q = {q_ff[22:0], 1'b0};
      end
      nxt_cnt = cnt_ff + 5'h01;
      if (cnt_ff == 5'(`IPS_DIV_BITS - 1))
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  // Register the divider state.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      q_ff <= 24'h00_0000;
      r_ff <= 17'h0_0000;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      q_ff <= nxt_q;
      r_ff <= nxt_r;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign dv.done = done_ff;
  assign dv.quot = q_ff;
endmodule // ips_div
`default_nettype wire

// ---- sim/ips_servo_model.sv ----
// Behavioural servo loop and homing switch facing the position sequencer.
`timescale 1ns/1ps
`default_nettype none
module ips_servo_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic move_start,
  input wire logic home_seek,
  input wire logic sense_hi,
  input wire logic [7:0] done_dly,
  output logic move_done_in,
  output logic home_sensor_in
);
  logic busy_ff; // A move is under way.
  logic [7:0] run_ff; // Cycles since the move began.
  logic [3:0] seek_ff; // Cycles of homing search so far.
  // A new start restarts the count; the model never sees an abort, so an aborted move still reports done unless a new start comes first.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      busy_ff <= 1'b0;
      run_ff <= 8'h00;
      seek_ff <= 4'h0;
      move_done_in <= 1'b0;
    end
    else
    begin
      move_done_in <= 1'b0;
      if (move_start)
      begin
        busy_ff <= 1'b1;
        run_ff <= 8'h00;
      end
      else if (busy_ff)
      begin
        run_ff <= run_ff + 8'h01;
        move_done_in <= (run_ff == done_dly);
        busy_ff <= (run_ff != done_dly);
      end
      seek_ff <= !home_seek ? 4'h0 : (seek_ff == 4'hf) ? seek_ff : seek_ff + 4'h1;
    end
  end
  // The switch is reached ten cycles into the search and reads inactive otherwise.
  assign home_sensor_in = (seek_ff >= 4'ha) ? sense_hi : !sense_hi;
endmodule // ips_servo_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the position sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ips_consts.svh"
module tb_top;
  import ips_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ips_word_t reg_rdata;
  logic [2:0] trg_n = 3'h7; // Home, move and stop pins; high is open.
  logic sen = 1'b1;
  logic cwl = 1'b1;
  logic ccwl = 1'b1;
  logic [5:0] psel = 6'h00;
  logic sense_hi = 1'b0;
  logic [7:0] srv_dly = 8'h03; // Servo answer delay, short unless a test needs it slow.
  logic hsen, mdone, drv_en, mstart, mcw, hseek, mabort, homed, got;
  ips_word_t tpos;
  logic [15:0] pvel, pacc, pdec;
  logic [15:0] rnd = 16'h35f7;
  int error_cnt = 0;
  int checks_done = 0;
  int rofs [64]; // Rotary offsets as written.
  int step, divs, last, exp, k, m, p, idx;
  always #12.5 ref_clk = ~ref_clk;
  ips_top u_ips_top (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .home_sensor_in(hsen), .home_trigger_in(trg_n[0]), .servo_enable_in(sen),
    .move_trigger_in(trg_n[1]), .cw_limit_in(cwl), .ccw_limit_in(ccwl),
    .stop_req_n(trg_n[2]), .point_select_in(psel), .move_done_in(mdone),
    .drive_enable(drv_en), .move_start(mstart), .target_pos(tpos), .move_cw(mcw),
    .prof_vel(pvel), .prof_acc(pacc), .prof_dec(pdec), .home_seek(hseek),
    .motion_abort(mabort), .homed(homed));
  ips_servo_model u_ips_servo_model (.ref_clk(ref_clk), .resetn(resetn),
    .move_start(mstart), .home_seek(hseek), .sense_hi(sense_hi), .done_dly(srv_dly),
    .move_done_in(mdone), .home_sensor_in(hsen));
  // Pseudo-random source with a fixed start.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One-cycle write; the strobe drops at the next edge, so calls never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, want);
  endtask
  // Bounded wait for an output (0 search, 1 move start, 2 abort), looked at from just after
  // the current edge so that a one-cycle pulse launched there is not missed.
  task automatic wait_hi(input int w, input int n);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++)
    begin
      #1;
      got = (((w == 0) ? hseek : (w == 1) ? mstart : mabort) === 1'b1);
      if (!got)
        @(posedge ref_clk);
    end
    if (!got)
    begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
    end
  endtask
  // Close a trigger pin for two cycles, long enough to pass the synchroniser.
  task automatic kick(input int i);
    @(posedge ref_clk);
    trg_n[i] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    trg_n[i] <= 1'b1;
  endtask
  task automatic settle();
    repeat (srv_dly + 8) @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk(drv_en, 0);
    chk(homed, 0);
    chk(mcw, 1);
    rd(`IPS_A_CTRL, 0);
    rd(`IPS_A_DIVS, 32'h0000_0018);
    rd(8'h80, 0);
    wr(`IPS_A_DIVS, 0);
    rd(`IPS_A_DIVS, 1);
    wr(`IPS_A_DIVS, 100);
    rd(`IPS_A_DIVS, 64);
    for (k = 0; k < 9; k++)
      wr(8'(`IPS_A_PROF0 + 4 * k), 32'h0000_0100 + 32'(k));
    wr(`IPS_A_HOFS, 32'hffff_fe0c);
    // Both enable senses against both pin levels.
    for (m = 0; m < 2; m++)
    begin
      for (p = 0; p < 2; p++)
      begin
        wr(`IPS_A_CTRL, 32'(m << 1));
        sen <= p[0];
        repeat (5) @(posedge ref_clk);
        #1;
        chk(drv_en, m == p);
      end
    end
    wr(`IPS_A_CTRL, 0);
    sen <= 1'b0;
    // A move trigger before homing must go unanswered.
    psel <= 6'h05;
    kick(1);
    got = 1'b0;
    repeat (15)
    begin
      @(posedge ref_clk);
      #1;
      got = got | (mstart === 1'b1);
    end
    chk(got, 0);
    // Homing: low-active sensor clockwise, then high-active counter-clockwise.
    for (k = 0; k < 2; k++)
    begin
      wr(`IPS_A_CTRL, (k == 1) ? 32'h0000_0014 : 32'h0000_0000);
      sense_hi <= k[0];
      kick(0);
      wait_hi(0, 10);
      chk(homed, 0);
      chk(mcw, k == 0);
      chk({pvel, pacc}, 32'h0106_0107);
      chk(pdec, 16'h0108);
      repeat (5) @(posedge ref_clk);
      #1;
      chk(hseek, 1);
      wait_hi(1, 40);
      chk(tpos, 32'hffff_fe0c);
      settle();
      #1;
      chk(homed, 1);
    end
    // Linear moves, index corners first, then random points; homing left the load at -500.
    wr(`IPS_A_CTRL, 0);
    last = -500;
    for (k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      idx = (k == 0) ? 0 : (k == 1) ? 63 : int'(rnd[5:0]);
      exp = 3 * int'($signed(rnd));
      wr(`IPS_A_PSEL, 32'(idx));
      wr(`IPS_A_LPOS, 32'(exp));
      psel <= 6'(idx);
      kick(1);
      wait_hi(1, 20);
      chk(tpos, 32'(exp));
      chk(pvel, 16'h0100);
      chk(mcw, exp >= last);
      last = exp;
      settle();
    end
    // Rotary steps: seven clockwise with a wrap, then two counter-clockwise.
    divs = 7;
    step = 0;
    wr(`IPS_A_DIVS, 7);
    for (k = 0; k < 7; k++)
    begin
      rofs[k] = 5 * k - 9;
      wr(`IPS_A_PSEL, 32'(k));
      wr(`IPS_A_ROFS, 32'(rofs[k]));
    end
    for (k = 0; k < 9; k++)
    begin
      if (k == 0 || k == 7)
        wr(`IPS_A_CTRL, (k == 7) ? 32'h0000_0009 : 32'h0000_0001);
      step = (k >= 7) ? (step + divs - 1) % divs : (step + 1) % divs;
      kick(1);
      wait_hi(1, 60);
      chk(tpos, 32'(step * 10000 / divs + rofs[step]));
      chk(mcw, k < 7);
      chk(pvel, 16'h0103);
      settle();
    end
    // Aborts with a slow servo: stop pin, clockwise limit, then the software stop bit.
    wr(`IPS_A_CTRL, 0);
    srv_dly <= 8'hc8;
    for (k = 0; k < 3; k++)
    begin
      wr(`IPS_A_PSEL, 9);
      wr(`IPS_A_LPOS, 32'h0100_0000 + 32'(k));
      psel <= 6'h09;
      kick(1);
      wait_hi(1, 20);
      chk(mcw, 1);
      repeat (5) @(posedge ref_clk);
      if (k == 0)
        kick(2);
      else if (k == 1)
        cwl <= 1'b0;
      else
        wr(`IPS_A_CTRL, 32'h0000_0020);
      wait_hi(2, 10);
      // The abort is a single-cycle pulse.
      @(posedge ref_clk);
      #1;
      chk(mabort, 0);
      cwl <= 1'b1;
      repeat (10) @(posedge ref_clk);
    end
    final_report();
  end
endmodule // tb_top
`default_nettype wire
